// *** inc/pwm_fault_cfg.svh ***
// Operation
// R1: System clock logic; timer tick only enables counting
// R2: Enabled guard trips on selected edge of source
// R3: Trip clears output modes, pins follow port bits
// R4: Guard enable cleared with output modes, same cycle
// R5: Raise fault interrupt when its enable set
// R6: Guard enable readable; cleared after trip
// R7: Fault pin default; comparator when select set
// R8: Software clears flag after changing fault setup
// R9: Both sources use same synchroniser and edge detector
// R10: Filter output changes after four equal samples
// R11: Filter adds four system-clock cycles, no prescaler
// R12: Port bit write can trigger fault path
// R13: One shared 2-bit high latch for wide registers
// R14: Low-byte write loads latch plus byte together
// R15: Low-byte read copies upper bits into latch
// R16: Write latch first; read low byte first
// R17: Main code masks interrupts around wide access
// R18: Fault flag set on event, software clears
`ifndef PWM_FAULT_CFG_SVH
`define PWM_FAULT_CFG_SVH

// ==========================================
// Register offsets on the 8-bit I/O bus
`define OFS_CTRL_A      6'h00
`define OFS_CTRL_D      6'h01
`define OFS_HIGH_LATCH  6'h02
`define OFS_COUNTER     6'h03
`define OFS_CMP_A       6'h04
`define OFS_CMP_B       6'h05
`define OFS_CMP_TOP     6'h06
`define OFS_CMP_D       6'h07
`define OFS_PORT_OUT    6'h08
`define OFS_PORT_DIR    6'h09

// ==========================================
// Field positions
`define CTLA_MODE_A_LSB 6
`define CTLA_MODE_B_LSB 4
`define CTLA_MODE_D_LSB 2
`define CTLD_GUARD_EN   7
`define CTLD_IRQ_EN     6
`define CTLD_COMP_SEL   5
`define CTLD_FILTER_EN  4
`define CTLD_EDGE_RISE  3
`define CTLD_FLAG       0
`define FAULT_PIN_BIT   6

// ==========================================
// Reset values and counts
`define RST_CTRL_A      8'h00
`define RST_CTRL_D      8'h00
`define RST_WIDE        10'h000
`define RST_TOP         10'h3ff
`define RST_PORT        8'h00
`define FILTER_SAMPLES  4

`endif

// *** inc/pwm_fault_pkg.sv ***
package pwm_fault_pkg;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] data;
    } io_req_t;

    typedef struct packed {
        logic guardEnable;
        logic irqEnable;
        logic compSelect;
        logic filterEnable;
        logic edgeRising;
    } fault_ctrl_t;

    typedef enum logic [1:0] {
        WIDE_COUNTER,
        WIDE_CMP_A,
        WIDE_CMP_B,
        WIDE_CMP_TOP
    } wide_sel_t;

endpackage

// *** hw/fault_input_filter.sv ***
`timescale 1ns/1ps
`include "pwm_fault_cfg.svh"

module fault_input_filter
#(
    parameter int SAMPLES = `FILTER_SAMPLES
)
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic rawIn,
    input  wire logic filterEnable,
    output logic      levelOut
);
    import pwm_fault_pkg::*;

    generate
        if (SAMPLES < 2)
        begin : gBadSamples
            $error("fault_input_filter needs at least two samples");
        end
    endgenerate

    logic [2:0]         syncChain;
    logic               syncLevel;
    logic [SAMPLES-2:0] history;
    logic               filtLevel;
    // Present sample joins the stored ones, so a change costs exactly SAMPLES cycles
    wire  [SAMPLES-1:0] window  = {history, syncLevel};
    wire                allHigh = &window;
    wire                allLow  = ~|window;

    // ==========================================
    // Three-stage sampler, level moves when stages two and three agree
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            syncChain <= 3'h0;
        else
            syncChain <= {syncChain[1:0], rawIn};
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            syncLevel <= 1'b0;
        else if (syncChain[1] == syncChain[2])
            syncLevel <= syncChain[2]; // [R9]
    end

    // ==========================================
    // Noise filter on system clock, adds SAMPLES cycles of delay
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            history <= '0;
        else
            history <= window[SAMPLES-2:0]; // [R11]
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            filtLevel <= 1'b0;
        else if (allHigh || allLow)
            filtLevel <= syncLevel; // [R10]
    end

    assign levelOut = filterEnable ? filtLevel : syncLevel;

endmodule

// *** hw/pwm_fault_guard.sv ***
`timescale 1ns/1ps
`include "pwm_fault_cfg.svh"

module pwm_fault_guard
#(
    parameter int WIDE = 10
)
(
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire pwm_fault_pkg::io_req_t ioReq,
    output logic [7:0]                  ioReadData,
    input  wire logic                   countTickEnable,
    input  wire logic                   faultPinInput,
    input  wire logic                   comparatorResult,
    output logic [7:0]                  portOut,
    output logic [7:0]                  portOutEnable,
    output logic                        faultIrq
);
    import pwm_fault_pkg::*;

    generate
        if (WIDE != 10)
        begin : gBadWide
            $error("pwm_fault_guard serves only a 10-bit counter");
        end
    endgenerate

    // ==========================================
    // Register state
    logic [7:0]      ctrlA;
    fault_ctrl_t     ctrlD;
    logic            faultFlag;
    logic [1:0]      highLatch;
    logic [WIDE-1:0] wideReg [4];
    logic [WIDE-1:0] cmpD;
    logic [7:0]      portReg;
    logic [7:0]      portDir;
    logic            countUp;

    // ==========================================
    // Address decode
    wire wrCtrlA   = ioReq.wr && ioReq.addr == `OFS_CTRL_A;
    wire wrCtrlD   = ioReq.wr && ioReq.addr == `OFS_CTRL_D;
    wire wrLatch   = ioReq.wr && ioReq.addr == `OFS_HIGH_LATCH;
    wire wrCounter = ioReq.wr && ioReq.addr == `OFS_COUNTER;
    wire wrCmpA    = ioReq.wr && ioReq.addr == `OFS_CMP_A;
    wire wrCmpB    = ioReq.wr && ioReq.addr == `OFS_CMP_B;
    wire wrCmpTop  = ioReq.wr && ioReq.addr == `OFS_CMP_TOP;
    wire wrCmpD    = ioReq.wr && ioReq.addr == `OFS_CMP_D;
    wire wrPort    = ioReq.wr && ioReq.addr == `OFS_PORT_OUT;
    wire wrDir     = ioReq.wr && ioReq.addr == `OFS_PORT_DIR;
    wire rdCounter = ioReq.rd && ioReq.addr == `OFS_COUNTER;
    wire rdCmpA    = ioReq.rd && ioReq.addr == `OFS_CMP_A;
    wire rdCmpB    = ioReq.rd && ioReq.addr == `OFS_CMP_B;
    wire rdCmpTop  = ioReq.rd && ioReq.addr == `OFS_CMP_TOP;
    wire rdCmpD    = ioReq.rd && ioReq.addr == `OFS_CMP_D;

    wire [3:0] wideWrite = {wrCmpTop, wrCmpB, wrCmpA, wrCounter};
    wire       flagClear = wrCtrlD && ioReq.data[`CTLD_FLAG];

    // Full value assembled from latch and written low byte
    wire [WIDE-1:0] wideWriteValue = {highLatch, ioReq.data}; // [R14]

    // ==========================================
    // Fault source selection and detection
    wire [1:0] sourceRaw;
    wire [1:0] sourceLevel;
    logic      prevLevel;

    // Pin driven as output by the port: software's value reaches the detector
    wire pinDriven = portDir[`FAULT_PIN_BIT];
    assign sourceRaw[0] = pinDriven ? portReg[`FAULT_PIN_BIT] : faultPinInput; // [R12]
    assign sourceRaw[1] = comparatorResult;

    genvar s;
    generate
        for (s = 0; s < 2; s++)
        begin : gSource
            fault_input_filter #(.SAMPLES(`FILTER_SAMPLES)) uFilter
            (
                .clk          (clk),
                .rst_n        (rst_n),
                .rawIn        (sourceRaw[s]),
                .filterEnable (ctrlD.filterEnable),
                .levelOut     (sourceLevel[s])
            ); // [R9]
        end
    endgenerate

    wire selLevel   = ctrlD.compSelect ? sourceLevel[1] : sourceLevel[0]; // [R7]
    wire riseEdge   = selLevel && !prevLevel;
    wire fallEdge   = !selLevel && prevLevel;
    wire faultEvent = ctrlD.edgeRising ? riseEdge : fallEdge; // [R2]
    wire faultTrip  = faultEvent && ctrlD.guardEnable; // [R2]

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            prevLevel <= 1'b0;
        else
            prevLevel <= selLevel;
    end

    // ==========================================
    // Control registers; a trip wins over a same-cycle software write
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ctrlA <= `RST_CTRL_A;
        else if (faultTrip)
            ctrlA <= 8'h00; // [R3]
        else if (wrCtrlA)
            ctrlA <= ioReq.data;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ctrlD <= fault_ctrl_t'(5'h00);
        else if (wrCtrlD)
        begin
            ctrlD.guardEnable  <= ioReq.data[`CTLD_GUARD_EN] && !faultTrip; // [R4]
            ctrlD.irqEnable    <= ioReq.data[`CTLD_IRQ_EN];
            ctrlD.compSelect   <= ioReq.data[`CTLD_COMP_SEL];
            ctrlD.filterEnable <= ioReq.data[`CTLD_FILTER_EN];
            ctrlD.edgeRising   <= ioReq.data[`CTLD_EDGE_RISE];
        end
        else if (faultTrip)
            ctrlD.guardEnable <= 1'b0; // [R4]
    end

    // Hardware set wins over the write-one clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            faultFlag <= 1'b0;
        else if (faultEvent)
            faultFlag <= 1'b1; // [R18]
        else if (flagClear)
            faultFlag <= 1'b0; // [R18]
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            faultIrq <= 1'b0;
        else
            faultIrq <= ctrlD.irqEnable && (faultFlag || faultEvent); // [R5]
    end

    // ==========================================
    // Shared high latch: loaded by write or by a low-byte read
    logic [1:0] readHigh;
    always_comb
    begin
        readHigh = highLatch;
        if (rdCounter)
            readHigh = wideReg[WIDE_COUNTER][WIDE-1:8];
        else if (rdCmpA)
            readHigh = wideReg[WIDE_CMP_A][WIDE-1:8];
        else if (rdCmpB)
            readHigh = wideReg[WIDE_CMP_B][WIDE-1:8];
        else if (rdCmpTop)
            readHigh = wideReg[WIDE_CMP_TOP][WIDE-1:8];
        else if (rdCmpD)
            readHigh = cmpD[WIDE-1:8];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            highLatch <= 2'h0;
        else if (wrLatch)
            highLatch <= ioReq.data[1:0]; // [R13]
        else
            highLatch <= readHigh; // [R15]
    end

    // ==========================================
    // Counter: runs on the system clock, the tick only enables it
    wire [WIDE-1:0] cnt    = wideReg[WIDE_COUNTER];
    wire [WIDE-1:0] top    = wideReg[WIDE_CMP_TOP];
    wire            atTop  = cnt == top;
    wire [WIDE-1:0] next_count = atTop ? '0 : cnt + 10'h001;

    genvar w;
    generate
        for (w = 0; w < 4; w++)
        begin : gWide
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    wideReg[w] <= (w == WIDE_CMP_TOP) ? `RST_TOP : `RST_WIDE;
                else if (wideWrite[w])
                    wideReg[w] <= wideWriteValue; // [R14]
                else if (w == WIDE_COUNTER && countTickEnable)
                    wideReg[w] <= next_count; // [R1]
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cmpD <= `RST_WIDE;
        else if (wrCmpD)
            cmpD <= wideWriteValue; // [R14]
    end

    // ==========================================
    // Port registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            portReg <= `RST_PORT;
            portDir <= `RST_PORT;
        end
        else
        begin
            if (wrPort)
                portReg <= ioReq.data;
            if (wrDir)
                portDir <= ioReq.data;
        end
    end

    // ==========================================
    // Waveforms and pin override
    wire [2:0] wave;
    wire [2:0] modeOn;
    assign wave[0]   = cnt < wideReg[WIDE_CMP_A];
    assign wave[1]   = cnt < wideReg[WIDE_CMP_B];
    assign wave[2]   = cnt < cmpD;
    assign modeOn[0] = |ctrlA[`CTLA_MODE_A_LSB +: 2];
    assign modeOn[1] = |ctrlA[`CTLA_MODE_B_LSB +: 2];
    assign modeOn[2] = |ctrlA[`CTLA_MODE_D_LSB +: 2];

    // Mode value 3 inverts the waveform, as in set-on-match operation
    wire [2:0] waveInv = {ctrlA[`CTLA_MODE_D_LSB +: 2] == 2'h3,
                          ctrlA[`CTLA_MODE_B_LSB +: 2] == 2'h3,
                          ctrlA[`CTLA_MODE_A_LSB +: 2] == 2'h3};

    logic [7:0] next_portOut;
    always_comb
    begin
        next_portOut = portReg;
        for (int c = 0; c < 3; c++)
        begin
            // Cleared modes hand the pin back to the port register
            if (modeOn[c] && !faultTrip)
                next_portOut[c] = wave[c] ^ waveInv[c]; // [R3]
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            portOut       <= `RST_PORT;
            portOutEnable <= `RST_PORT;
        end
        else
        begin
            portOut       <= next_portOut;
            portOutEnable <= portDir;
        end
    end

    // ==========================================
    // Read data, valid the cycle after the read strobe
    wire [7:0] ctrlDRead = {ctrlD.guardEnable, ctrlD.irqEnable, ctrlD.compSelect,
                            ctrlD.filterEnable, ctrlD.edgeRising, 2'h0, faultFlag}; // [R6]

    logic [7:0] next_read;
    always_comb
    begin
        unique case (ioReq.addr)
            `OFS_CTRL_A:     next_read = ctrlA;
            `OFS_CTRL_D:     next_read = ctrlDRead;
            `OFS_HIGH_LATCH: next_read = {6'h00, highLatch};
            `OFS_COUNTER:    next_read = wideReg[WIDE_COUNTER][7:0];
            `OFS_CMP_A:      next_read = wideReg[WIDE_CMP_A][7:0];
            `OFS_CMP_B:      next_read = wideReg[WIDE_CMP_B][7:0];
            `OFS_CMP_TOP:    next_read = wideReg[WIDE_CMP_TOP][7:0];
            `OFS_CMP_D:      next_read = cmpD[7:0];
            `OFS_PORT_OUT:   next_read = portReg;
            `OFS_PORT_DIR:   next_read = portDir;
            default:         next_read = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ioReadData <= 8'h00;
        else if (ioReq.rd)
            ioReadData <= next_read;
    end

endmodule

// *** dv/pwm_fault_guard_props.sv ***
`timescale 1ns/1ps
`include "pwm_fault_cfg.svh"
module pwm_fault_guard_props
(
    input wire logic                   clk,
    input wire logic                   rst_n,
    input wire pwm_fault_pkg::io_req_t ioReq,
    input wire logic [7:0]             ioReadData,
    input wire logic                   countTickEnable,
    input wire logic                   faultPinInput,
    input wire logic                   comparatorResult,
    input wire logic [7:0]             portOut,
    input wire logic [7:0]             portOutEnable,
    input wire logic                   faultIrq
);
    import pwm_fault_pkg::*;
    logic       prevPin;
    logic       prevCmp;
    logic [4:0] quiet;
    wire wrD   = ioReq.wr && ioReq.addr == `OFS_CTRL_D;
    wire wrH   = ioReq.wr && ioReq.addr == `OFS_HIGH_LATCH;
    wire rdH   = ioReq.rd && ioReq.addr == `OFS_HIGH_LATCH;
    wire inCmp = ioReq.addr >= `OFS_CMP_A && ioReq.addr <= `OFS_CMP_D;
    wire chg   = faultPinInput != prevPin || comparatorResult != prevCmp || ioReq.wr;
    // ==========================================
    // Cycles since anything that may raise the interrupt
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prevPin <= 1'b0;
            prevCmp <= 1'b0;
            quiet   <= 5'h00;
        end
        else
        begin
            prevPin <= faultPinInput;
            prevCmp <= comparatorResult;
            quiet   <= chg ? 5'h00 : (quiet == 5'h1f ? quiet : quiet + 5'h01);
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_IRQ_FALL: assert property ($fell(faultIrq) |-> $past(wrD) || $past(wrD, 2))
        else $error("interrupt dropped without a control write");
    AST_IRQ_CAUSE: assert property ($rose(faultIrq) |-> quiet < 5'h14)
        else $error("interrupt raised without a recent cause");
    AST_DIR_WR: assert property (ioReq.wr && ioReq.addr == `OFS_PORT_DIR ##1 !ioReq.wr
        |=> portOutEnable == $past(ioReq.data, 2)) else $error("pin enables wrong");
    AST_PORT_WR: assert property (ioReq.wr && ioReq.addr == `OFS_PORT_OUT ##1 !ioReq.wr
        |=> portOut[7:3] == $past(ioReq.data[7:3], 2)) else $error("port bits wrong");
    AST_RD_HOLD: assert property (!ioReq.rd |=> $stable(ioReadData))
        else $error("read data moved without a read");
    AST_LATCH_RD: assert property (wrH ##1 !ioReq.wr && !ioReq.rd ##1 rdH
        |=> ioReadData == {6'h00, $past(ioReq.data[1:0], 3)}) else $error("latch readback");
    AST_WIDE_LOW: assert property (wrH ##1 ioReq.wr && inCmp
        ##1 ioReq.rd && ioReq.addr == $past(ioReq.addr)
        |=> ioReadData == $past(ioReq.data, 2)) else $error("low byte readback");
    AST_WIDE_HIGH: assert property (wrH ##1 ioReq.wr && inCmp
        ##1 ioReq.rd && ioReq.addr == $past(ioReq.addr) ##1 rdH
        |=> ioReadData == {6'h00, $past(ioReq.data[1:0], 4)}) else $error("high bits readback");
endmodule

bind pwm_fault_guard pwm_fault_guard_props u_pwm_fault_guard_props
(
    .clk(clk), .rst_n(rst_n), .ioReq(ioReq), .ioReadData(ioReadData),
    .countTickEnable(countTickEnable), .faultPinInput(faultPinInput),
    .comparatorResult(comparatorResult), .portOut(portOut),
    .portOutEnable(portOutEnable), .faultIrq(faultIrq)
);

// *** dv/cpu_bus_model.sv ***
`timescale 1ns/1ps
`include "pwm_fault_cfg.svh"
module cpu_bus_model
(
    input wire logic               clk,
    input wire logic [7:0]         ioReadData,
    output pwm_fault_pkg::io_req_t ioReq
);
    import pwm_fault_pkg::*;
    logic [7:0] seen;
    initial ioReq = '0;
    // Read data lands at the taking edge; sampled half a cycle later to avoid the race
    always @(negedge clk) seen <= ioReadData;
    task automatic go(input logic w, input logic [5:0] a, input logic [7:0] d);
        ioReq <= '{w, !w, a, d};
        @(posedge clk);
    endtask
    task automatic wr8(input logic [5:0] a, input logic [7:0] d);
        go(1'b1, a, d);
        ioReq <= '0;
        @(posedge clk);
    endtask
    task automatic rd8(input logic [5:0] a, output logic [7:0] d);
        go(1'b0, a, 8'h00);
        ioReq <= '0;
        @(posedge clk);
        d = seen;
    endtask
    // Low byte first so the latch picks up this register's top bits
    task automatic rdWide(input logic [5:0] a, output logic [7:0] lo, output logic [7:0] hi);
        go(1'b0, a, 8'h00);
        go(1'b0, `OFS_HIGH_LATCH, 8'h00);
        lo = seen;
        ioReq <= '0;
        @(posedge clk);
        hi = seen;
    endtask
    // Latch before low byte; one caller only, so nothing slips in between
    task automatic wideRw(input logic [5:0] a, input logic [9:0] v,
                          output logic [7:0] lo, output logic [7:0] hi);
        go(1'b1, `OFS_HIGH_LATCH, {6'h00, v[9:8]});
        go(1'b1, a, v[7:0]);
        rdWide(a, lo, hi);
    endtask
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`include "pwm_fault_cfg.svh"
module tb_top;
    import pwm_fault_pkg::*;
    typedef struct { logic [5:0] a; logic [9:0] v; } row_t;
    logic       clk;
    logic       rst_n;
    logic       tick;
    logic       pin;
    logic       cmp;
    logic       irq;
    io_req_t    ioReq;
    logic [7:0] rdData;
    logic [7:0] portOut;
    logic [7:0] portOutEnable;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] v;
    int         mismatches;
    int         n_tests;
    int         latA;
    int         latB;
    row_t       rows [5] = '{'{`OFS_COUNTER, 10'h1ff}, '{`OFS_CMP_A, 10'h2a5},
                            '{`OFS_CMP_B, 10'h000}, '{`OFS_CMP_TOP, 10'h3ff},
                            '{`OFS_CMP_D, 10'h155}};
    pwm_fault_guard u_pwm_fault_guard
    (
        .clk(clk), .rst_n(rst_n), .ioReq(ioReq), .ioReadData(rdData),
        .countTickEnable(tick), .faultPinInput(pin), .comparatorResult(cmp),
        .portOut(portOut), .portOutEnable(portOutEnable), .faultIrq(irq)
    );
    cpu_bus_model u_cpu_bus_model (.clk(clk), .ioReadData(rdData), .ioReq(ioReq));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ==========================================
    // Checking helpers
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic waitIrq(output int n);
        n = 0;
        while (irq !== 1'b1 && n < 40)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 40)
        begin
            mismatches++;
            $display("Error at %0t: interrupt timeout", $time);
        end
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        #(4000 * 100);
        mismatches++;
        $display("Error at %0t: watchdog expired", $time);
        stop_test;
    end
    // ==========================================
    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        tick = 1'b0;
        pin = 1'b0;
        cmp = 1'b1;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 5; i++)
        begin
            u_cpu_bus_model.wideRw(rows[i].a, rows[i].v, lo, hi);
            chk8(lo, rows[i].v[7:0]);
            chk8(hi, {6'h00, rows[i].v[9:8]});
        end
        $display("test wide rows done");
        // Mid-run reset: outputs drop at once, registers return to reset values
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk8(rdData, 8'h00);
        chk8(portOut, `RST_PORT);
        chk8(portOutEnable, `RST_PORT);
        chk1(irq, 1'b0);
        rst_n <= 1'b1;
        @(posedge clk);
        u_cpu_bus_model.rdWide(`OFS_CMP_TOP, lo, hi);
        chk8(lo, 8'hff);
        chk8(hi, 8'h03);
        u_cpu_bus_model.rdWide(`OFS_COUNTER, lo, hi);
        chk8(lo, 8'h00);
        chk8(hi, 8'h00);
        u_cpu_bus_model.rd8(`OFS_CTRL_D, v);
        chk8(v, `RST_CTRL_D);
        $display("test reset done");
        // One latch write serves two registers; a low read then overwrites it
        u_cpu_bus_model.wr8(`OFS_HIGH_LATCH, 8'h03);
        u_cpu_bus_model.rd8(`OFS_HIGH_LATCH, v);
        chk8(v, 8'h03);
        u_cpu_bus_model.wr8(`OFS_CMP_A, 8'h11);
        u_cpu_bus_model.wr8(`OFS_CMP_B, 8'h22);
        u_cpu_bus_model.rdWide(`OFS_CMP_B, lo, hi);
        chk8(lo, 8'h22);
        chk8(hi, 8'h03);
        u_cpu_bus_model.wr8(`OFS_HIGH_LATCH, 8'h00);
        u_cpu_bus_model.rd8(`OFS_CMP_A, v);
        chk8(v, 8'h11);
        u_cpu_bus_model.rd8(`OFS_HIGH_LATCH, v);
        chk8(v, 8'h03);
        u_cpu_bus_model.rd8(6'h3f, v);
        chk8(v, 8'h00);
        $display("test latch done");
        // Three enabled ticks from just below top wrap through zero
        u_cpu_bus_model.wideRw(`OFS_COUNTER, 10'h3fe, lo, hi);
        tick <= 1'b1;
        repeat (3) @(posedge clk);
        tick <= 1'b0;
        u_cpu_bus_model.rdWide(`OFS_COUNTER, lo, hi);
        chk8(lo, 8'h01);
        chk8(hi, 8'h00);
        $display("test count done");
        u_cpu_bus_model.wr8(`OFS_PORT_DIR, 8'h07);
        u_cpu_bus_model.wr8(`OFS_PORT_OUT, 8'h05);
        u_cpu_bus_model.wr8(`OFS_CTRL_A, 8'ha8);
        u_cpu_bus_model.wr8(`OFS_CTRL_D, 8'hc8);
        u_cpu_bus_model.wr8(`OFS_CTRL_D, 8'hc9);
        // Before the trip: A and B high, D low since its compare is back at zero
        chk8(portOut, 8'h03);
        pin <= 1'b1;
        waitIrq(latA);
        chk1(irq, 1'b1);
        u_cpu_bus_model.rd8(`OFS_CTRL_A, v);
        chk8(v, 8'h00);
        u_cpu_bus_model.rd8(`OFS_CTRL_D, v);
        chk8(v, 8'h49);
        chk8(portOut, 8'h05);
        chk8(portOutEnable, 8'h07);
        u_cpu_bus_model.wr8(`OFS_CTRL_D, 8'h41);
        @(negedge clk);
        chk1(irq, 1'b0);
        $display("test pin fault done");
        // Comparator source, falling edge, filtered: a short glitch must not pass
        u_cpu_bus_model.wr8(`OFS_CTRL_D, 8'hf0);
        u_cpu_bus_model.wr8(`OFS_CTRL_D, 8'hf1);
        cmp <= 1'b0;
        repeat (2) @(posedge clk);
        cmp <= 1'b1;
        pin <= 1'b0;
        repeat (20) @(posedge clk);
        u_cpu_bus_model.rd8(`OFS_CTRL_D, v);
        chk8(v, 8'hf0);
        cmp <= 1'b0;
        waitIrq(latB);
        chk1(irq, 1'b1);
        chk8(8'(latB - latA), 8'h04);
        u_cpu_bus_model.rd8(`OFS_CTRL_D, v);
        chk8(v, 8'h71);
        $display("test comparator fault done");
        u_cpu_bus_model.wr8(`OFS_PORT_DIR, 8'h47);
        u_cpu_bus_model.wr8(`OFS_CTRL_D, 8'hc9);
        u_cpu_bus_model.wr8(`OFS_PORT_OUT, 8'h45);
        waitIrq(latA);
        chk1(irq, 1'b1);
        u_cpu_bus_model.rd8(`OFS_CTRL_D, v);
        chk8(v, 8'h49);
        $display("test software trigger done");
        stop_test;
    end
endmodule
